// >>> common/lowspeed_timing_consts.svh
// Summary of operation
// - fourteen-bit low-speed start limit, in full-speed bit times, software writable.
// - low-speed transaction starts only while frame time left exceeds the limit.
// - eight-bit port power settle field in top byte, two milliseconds per unit.
// - port power settle field is storage only and steers no logic.
// - fourteen-bit frame time left counter reloads from frame length each frame.
// - frame length plus one counts 12 MHz periods per frame, setting frame span.
`ifndef LOWSPEED_TIMING_CONSTS_SVH
`define LOWSPEED_TIMING_CONSTS_SVH

// register byte offsets
`define CTRL_OFS 12'h004
`define FRAME_LENGTH_OFS 12'h034
`define FRAME_LEFT_OFS 12'h038
`define FRAME_NUM_OFS 12'h03C
`define LS_LIMIT_OFS 12'h044
`define RHDA_OFS 12'h048
`define DEFER_CNT_OFS 12'h054

// field positions
`define FIELD14_MSB 13
`define TOGGLE_BIT 31
`define FSMPS_MSB 30
`define FSMPS_LSB 16
`define SETTLE_MSB 31
`define SETTLE_LSB 24
`define NOCP_BIT 12
`define OCPM_BIT 11
`define NPS_BIT 9
`define PSM_BIT 8

// reset values
`define FRAME_LENGTH_RST 14'h2EDF
`define FSMPS_RST 15'h0000
`define LS_LIMIT_RST 14'h0628
`define SETTLE_RST 8'h01
`define NDP_RST 8'h03

// timing
`define SETTLE_UNIT_MS 2
`define REF_RATE_KHZ 125000
`define BIT_RATE_KHZ 12000

`endif

// >>> common/lowspeed_timing_pkg.sv
package lowspeed_timing_pkg;

   typedef enum logic [1:0] {
      RESP_OKAY = 2'b00,
      RESP_SLVERR = 2'b10
   } resp_t;

   typedef enum logic [0:0] {
      FRAME_IDLE = 1'b0,
      FRAME_RUN = 1'b1
   } frame_state_t;

endpackage : lowspeed_timing_pkg

// >>> core/bit_time_tick.sv
`timescale 1ns/1ns
// fractional divider: NUM ticks every DEN reference cycles
module bit_time_tick #(
   parameter int unsigned NUM = 12,
   parameter int unsigned DEN = 125,
   parameter int unsigned ACC_W = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control and result
   input wire logic enable,
   output logic tick
);

   logic [ACC_W-1:0] acc_q;
   logic [ACC_W:0] sum;

   assign sum = {1'b0, acc_q} + NUM[ACC_W:0];

   // jitter of one reference cycle per tick, average rate exact
   always_ff @(posedge clk) begin
      if (rst || !enable) begin
         acc_q <= '0;
         tick <= 1'b0;
      end else if (sum >= DEN[ACC_W:0]) begin
         acc_q <= ACC_W'(sum - DEN[ACC_W:0]);
         tick <= 1'b1;
      end else begin
         acc_q <= sum[ACC_W-1:0];
         tick <= 1'b0;
      end
   end

endmodule : bit_time_tick

// >>> core/lowspeed_threshold_roothub_timing.sv
`timescale 1ns/1ns
`include "lowspeed_timing_consts.svh"

module lowspeed_threshold_roothub_timing
   import lowspeed_timing_pkg::*;
#(
   parameter int unsigned ADDR_W = 12,
   parameter int unsigned FIELD_W = 14,
   parameter logic [7:0] NUM_PORTS = `NDP_RST
) (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RST,
   // axi4-lite write address
   input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic [2:0] S_AXI_AWPROT,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   // axi4-lite write data
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   // axi4-lite write response
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   // axi4-lite read address
   input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic [2:0] S_AXI_ARPROT,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   // axi4-lite read data
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // scheduler side
   input wire logic LS_REQ,
   output logic LS_GO,
   output logic LS_DEFER,
   output logic FRAME_START,
   output logic [FIELD_W-1:0] FRAME_LEFT
);

   // write channel capture
   logic aw_have_q;
   logic [ADDR_W-1:0] aw_addr_q;
   logic w_have_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic bvalid_q;
   resp_t bresp_q;
   logic do_write;

   // read channel
   logic rvalid_q;
   logic [31:0] rdata_q;
   resp_t rresp_q;
   logic [31:0] rd_val;
   logic rd_hit;

   // write decode
   logic wr_ctrl;
   logic wr_frame_length;
   logic wr_ls_limit;
   logic wr_rhda;
   logic wr_defer;
   logic wr_hit;
   logic [31:0] wr_mask;

   // register state
   frame_state_t state_q;
   logic [FIELD_W-1:0] frame_length_q;
   logic [14:0] fsmps_q;
   logic fit_q;
   logic [FIELD_W-1:0] left_q;
   logic frt_q;
   logic [15:0] frame_num_q;
   logic [FIELD_W-1:0] ls_limit_q;
   logic [7:0] settle_q;
   logic nocp_q;
   logic ocpm_q;
   logic nps_q;
   logic psm_q;
   logic [15:0] defer_cnt_q;
   logic frame_start_q;

   // frame timing
   logic bit_tick;
   logic ls_ok;
   logic defer_now;

   function automatic logic [31:0] strb_mask(input logic [3:0] strb);
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{strb[i]}};
      end
      return m;
   endfunction : strb_mask

   assign S_AXI_AWREADY = !aw_have_q;
   assign S_AXI_WREADY = !w_have_q;
   assign S_AXI_BVALID = bvalid_q;
   assign S_AXI_BRESP = bresp_q;
   assign S_AXI_ARREADY = !rvalid_q;
   assign S_AXI_RVALID = rvalid_q;
   assign S_AXI_RDATA = rdata_q;
   assign S_AXI_RRESP = rresp_q;

   // address and data may come in either order
   assign do_write = aw_have_q && w_have_q && !bvalid_q;
   assign wr_mask = strb_mask(w_strb_q);

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         aw_have_q <= 1'b0;
         aw_addr_q <= '0;
      end else if (S_AXI_AWVALID && !aw_have_q) begin
         aw_have_q <= 1'b1;
         aw_addr_q <= S_AXI_AWADDR;
      end else if (do_write) begin
         aw_have_q <= 1'b0;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         w_have_q <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end else if (S_AXI_WVALID && !w_have_q) begin
         w_have_q <= 1'b1;
         w_data_q <= S_AXI_WDATA;
         w_strb_q <= S_AXI_WSTRB;
      end else if (do_write) begin
         w_have_q <= 1'b0;
      end
   end

   always_comb begin
      wr_ctrl = 1'b0;
      wr_frame_length = 1'b0;
      wr_ls_limit = 1'b0;
      wr_rhda = 1'b0;
      wr_defer = 1'b0;
      wr_hit = 1'b1;
      if (aw_addr_q == `CTRL_OFS) begin
         wr_ctrl = do_write;
      end else if (aw_addr_q == `FRAME_LENGTH_OFS) begin
         wr_frame_length = do_write;
      end else if (aw_addr_q == `LS_LIMIT_OFS) begin
         wr_ls_limit = do_write;
      end else if (aw_addr_q == `RHDA_OFS) begin
         wr_rhda = do_write;
      end else if (aw_addr_q == `DEFER_CNT_OFS) begin
         wr_defer = do_write;
      end else if (aw_addr_q == `FRAME_LEFT_OFS || aw_addr_q == `FRAME_NUM_OFS) begin
         wr_hit = 1'b1;
      end else begin
         wr_hit = 1'b0;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else if (do_write) begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
         bvalid_q <= 1'b0;
      end
   end

   // reserved positions are constant zero in every read
   always_comb begin
      rd_val = 32'h0000_0000;
      rd_hit = 1'b1;
      if (S_AXI_ARADDR == `CTRL_OFS) begin
         rd_val[0] = (state_q == FRAME_RUN);
      end else if (S_AXI_ARADDR == `FRAME_LENGTH_OFS) begin
         rd_val[`TOGGLE_BIT] = fit_q;
         rd_val[`FSMPS_MSB:`FSMPS_LSB] = fsmps_q;
         rd_val[`FIELD14_MSB:0] = frame_length_q;
      end else if (S_AXI_ARADDR == `FRAME_LEFT_OFS) begin
         rd_val[`TOGGLE_BIT] = frt_q;
         rd_val[`FIELD14_MSB:0] = left_q;
      end else if (S_AXI_ARADDR == `FRAME_NUM_OFS) begin
         rd_val[15:0] = frame_num_q;
      end else if (S_AXI_ARADDR == `LS_LIMIT_OFS) begin
         rd_val[`FIELD14_MSB:0] = ls_limit_q;
      end else if (S_AXI_ARADDR == `RHDA_OFS) begin
         rd_val[`SETTLE_MSB:`SETTLE_LSB] = settle_q;
         rd_val[`NOCP_BIT] = nocp_q;
         rd_val[`OCPM_BIT] = ocpm_q;
         rd_val[`NPS_BIT] = nps_q;
         rd_val[`PSM_BIT] = psm_q;
         rd_val[7:0] = NUM_PORTS;
      end else if (S_AXI_ARADDR == `DEFER_CNT_OFS) begin
         rd_val[15:0] = defer_cnt_q;
      end else begin
         rd_hit = 1'b0;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= RESP_OKAY;
      end else if (S_AXI_ARVALID && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_val;
         rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
         rvalid_q <= 1'b0;
      end
   end

   // run control
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         state_q <= FRAME_IDLE;
      end else if (wr_ctrl && w_strb_q[0]) begin
         state_q <= w_data_q[0] ? FRAME_RUN : FRAME_IDLE;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         frame_length_q <= `FRAME_LENGTH_RST;
         fsmps_q <= `FSMPS_RST;
         fit_q <= 1'b0;
      end else if (wr_frame_length) begin
         frame_length_q <= (frame_length_q & ~wr_mask[`FIELD14_MSB:0])
                           | (w_data_q[`FIELD14_MSB:0] & wr_mask[`FIELD14_MSB:0]);
         fsmps_q <= (fsmps_q & ~wr_mask[`FSMPS_MSB:`FSMPS_LSB])
                    | (w_data_q[`FSMPS_MSB:`FSMPS_LSB] & wr_mask[`FSMPS_MSB:`FSMPS_LSB]);
         if (w_strb_q[3]) begin
            fit_q <= w_data_q[`TOGGLE_BIT];
         end
      end
   end

   // software is expected to write the limit once and leave it
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         ls_limit_q <= `LS_LIMIT_RST;
      end else if (wr_ls_limit) begin
         ls_limit_q <= (ls_limit_q & ~wr_mask[`FIELD14_MSB:0])
                       | (w_data_q[`FIELD14_MSB:0] & wr_mask[`FIELD14_MSB:0]);
      end
   end

   // settle time only stored: software times the port power delay
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         settle_q <= `SETTLE_RST;
         nocp_q <= 1'b1;
         ocpm_q <= 1'b0;
         nps_q <= 1'b1;
         psm_q <= 1'b0;
      end else if (wr_rhda) begin
         if (w_strb_q[3]) begin
            settle_q <= w_data_q[`SETTLE_MSB:`SETTLE_LSB];
         end
         if (w_strb_q[1]) begin
            nocp_q <= w_data_q[`NOCP_BIT];
            ocpm_q <= w_data_q[`OCPM_BIT];
            nps_q <= w_data_q[`NPS_BIT];
            psm_q <= w_data_q[`PSM_BIT];
         end
      end
   end

   bit_time_tick #(
      .NUM(`BIT_RATE_KHZ / 1000),
      .DEN(`REF_RATE_KHZ / 1000),
      .ACC_W(8)
   ) bit_time_tick_inst (
      .clk(REF_CLK),
      .rst(RST),
      .enable(state_q == FRAME_RUN),
      .tick(bit_tick)
   );

   // counter spans frame_length_q + 1 bit times per frame
   always_ff @(posedge REF_CLK) begin
      if (RST || state_q == FRAME_IDLE) begin
         left_q <= '0;
         frt_q <= 1'b0;
         frame_start_q <= 1'b0;
      end else if (bit_tick && left_q == '0) begin
         left_q <= frame_length_q;
         frt_q <= fit_q;
         frame_start_q <= 1'b1;
      end else if (bit_tick) begin
         left_q <= left_q - 1'b1;
         frame_start_q <= 1'b0;
      end else begin
         frame_start_q <= 1'b0;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         frame_num_q <= 16'h0000;
      end else if (state_q == FRAME_RUN && bit_tick && left_q == '0) begin
         frame_num_q <= frame_num_q + 1'b1;
      end
   end

   // strict compare: equal leaves no room for the packet
   assign ls_ok = (state_q == FRAME_RUN) && (left_q > ls_limit_q);
   assign LS_GO = LS_REQ && ls_ok;
   assign defer_now = LS_REQ && !ls_ok;
   assign LS_DEFER = defer_now;

   // a deferral in the clearing cycle still counts
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         defer_cnt_q <= 16'h0000;
      end else if (defer_now) begin
         if (wr_defer) begin
            defer_cnt_q <= 16'h0001;
         end else if (defer_cnt_q != 16'hFFFF) begin
            defer_cnt_q <= defer_cnt_q + 1'b1;
         end
      end else if (wr_defer) begin
         defer_cnt_q <= 16'h0000;
      end
   end

   assign FRAME_START = frame_start_q;
   assign FRAME_LEFT = left_q;

endmodule : lowspeed_threshold_roothub_timing

// >>> verification/lowspeed_timing_monitor.sv
`timescale 1ns/1ns
module lowspeed_timing_monitor #(
   parameter int unsigned FIELD_W = 14
) (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RST,
   // register bus
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic S_AXI_WVALID,
   input wire logic S_AXI_WREADY,
   input wire logic [1:0] S_AXI_BRESP,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // scheduler side
   input wire logic LS_REQ,
   input wire logic LS_GO,
   input wire logic LS_DEFER,
   input wire logic FRAME_START,
   input wire logic [FIELD_W-1:0] FRAME_LEFT
);
   default clocking cb @(posedge REF_CLK); endclocking

   chk_go_or_defer: assert property (disable iff (RST) LS_REQ |-> LS_GO != LS_DEFER)
      else $error("request neither started nor deferred");
   chk_no_req_idle: assert property (disable iff (RST) !LS_REQ |-> !LS_GO && !LS_DEFER)
      else $error("start or defer without request");
   chk_frame_reload: assert property (disable iff (RST)
      $past(FRAME_LEFT) == 0 && FRAME_LEFT != 0 |-> ##[0:1] FRAME_START)
      else $error("reload without frame start pulse");
   chk_count_down: assert property (disable iff (RST) $past(FRAME_LEFT) != 0 && FRAME_LEFT != 0
      |-> FRAME_LEFT == $past(FRAME_LEFT) || FRAME_LEFT == $past(FRAME_LEFT) - 1)
      else $error("frame time left jumped");
   chk_bresp_hold: assert property (disable iff (RST)
      S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write response dropped early");
   chk_rdata_hold: assert property (disable iff (RST)
      S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read data dropped early");
   chk_read_lat: assert property (disable iff (RST) S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read answer late");
   chk_write_lat: assert property (disable iff (RST) S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
      && S_AXI_WREADY |=> ##1 S_AXI_BVALID)
      else $error("write answer late");
   chk_reset_state: assert property (RST |=> S_AXI_AWREADY && !S_AXI_BVALID && !S_AXI_RVALID
      && FRAME_LEFT == 0)
      else $error("reset state wrong");

   cover property (LS_GO);
   cover property (LS_DEFER && FRAME_LEFT != 0);
   cover property (FRAME_START);
endmodule : lowspeed_timing_monitor

bind lowspeed_threshold_roothub_timing lowspeed_timing_monitor #(.FIELD_W(FIELD_W)) lowspeed_timing_monitor_inst (
   .REF_CLK, .RST, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP,
   .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID,
   .S_AXI_RREADY, .LS_REQ, .LS_GO, .LS_DEFER, .FRAME_START, .FRAME_LEFT);

// >>> verification/ls_requester.sv
`timescale 1ns/1ns
module ls_requester (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control and handshake
   input wire logic en,
   input wire logic go,
   output logic req
);
   // gap after each start, so both edges of the request are exercised
   always_ff @(posedge clk) begin
      if (rst || !en) req <= 1'b0;
      else req <= !go && ($urandom % 4 != 0);
   end
endmodule : ls_requester

// >>> verification/lowspeed_threshold_roothub_timing_tb_top.sv
`timescale 1ns/1ns
module lowspeed_threshold_roothub_timing_tb_top;
   import lowspeed_timing_pkg::*;
   localparam int FLEN = 40;
   localparam int LO = (FLEN + 1) * 125 / 12;
   logic REF_CLK, RST, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
   logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY, LS_REQ, LS_GO, LS_DEFER, FRAME_START;
   logic [11:0] S_AXI_AWADDR, S_AXI_ARADDR;
   logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
   logic [3:0] S_AXI_WSTRB;
   logic [2:0] S_AXI_AWPROT, S_AXI_ARPROT;
   logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
   logic [13:0] FRAME_LEFT, lim;
   logic req_en, run_on;
   logic [33:0] e;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   int error_cnt, n_checks, n_defer, n_frames;

   lowspeed_threshold_roothub_timing lowspeed_threshold_roothub_timing_inst (.REF_CLK, .RST, .S_AXI_AWADDR,
      .S_AXI_AWPROT, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY,
      .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARPROT, .S_AXI_ARVALID, .S_AXI_ARREADY,
      .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .LS_REQ, .LS_GO, .LS_DEFER, .FRAME_START,
      .FRAME_LEFT);
   ls_requester ls_requester_inst (.clk(REF_CLK), .rst(RST), .en(req_en), .go(LS_GO), .req(LS_REQ));

   initial begin
      REF_CLK = 1'b0;
      forever #4 REF_CLK = ~REF_CLK;
   end

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task give_verdict;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : give_verdict

   task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input resp_t er);
      logic pa, pw, ta, tw;
      bq.push_back(er);
      pa = 1'b1;
      pw = 1'b1;
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= d;
      S_AXI_WSTRB <= s;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      while (pa || pw) begin
         @(negedge REF_CLK);
         ta = pa && S_AXI_AWREADY;
         tw = pw && S_AXI_WREADY;
         @(posedge REF_CLK);
         if (ta) S_AXI_AWVALID <= 1'b0;
         if (tw) S_AXI_WVALID <= 1'b0;
         pa = pa && !ta;
         pw = pw && !tw;
      end
      do @(negedge REF_CLK); while (!(S_AXI_BVALID && S_AXI_BREADY));
      @(posedge REF_CLK);
   endtask : wr

   task rd(input logic [11:0] a, input logic [31:0] d, input resp_t er);
      rq.push_back({er, d});
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'b1;
      do @(negedge REF_CLK); while (!S_AXI_ARREADY);
      @(posedge REF_CLK);
      S_AXI_ARVALID <= 1'b0;
      do @(negedge REF_CLK); while (!(S_AXI_RVALID && S_AXI_RREADY));
      @(posedge REF_CLK);
   endtask : rd

   task frame_mark(output time t);
      do @(negedge REF_CLK); while (FRAME_START !== 1'b1);
      t = $time;
      chk({18'h0, FRAME_LEFT}, FLEN);
      @(posedge REF_CLK);
   endtask : frame_mark

   // response watcher plus ready stalls; ready stays up until its answer
   always @(posedge REF_CLK) begin
      if (!RST && S_AXI_BVALID && S_AXI_BREADY) chk({30'h0, S_AXI_BRESP}, {30'h0, bq.pop_front()});
      if (!RST && S_AXI_RVALID && S_AXI_RREADY) begin
         e = rq.pop_front();
         chk(S_AXI_RDATA, e[31:0]);
         chk({30'h0, S_AXI_RRESP}, {30'h0, e[33:32]});
      end
      if (!S_AXI_BREADY || S_AXI_BVALID) S_AXI_BREADY <= 1'($urandom % 2);
      if (!S_AXI_RREADY || S_AXI_RVALID) S_AXI_RREADY <= 1'($urandom % 2);
      if (run_on && LS_REQ) chk({31'h0, LS_GO}, {31'h0, FRAME_LEFT > lim});
      if (run_on && LS_REQ) chk({31'h0, LS_DEFER}, {31'h0, FRAME_LEFT <= lim});
      if (run_on && LS_REQ && FRAME_LEFT <= lim) n_defer++;
      if (FRAME_START) n_frames++;
   end

   // timeout: the scenarios need a few thousand cycles
   initial begin
      repeat (20000) @(posedge REF_CLK);
      error_cnt++;
      give_verdict();
   end

   initial begin
      logic [7:0] s;
      time t0, t1;
      void'($urandom(32'hd4ac));
      {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_ARVALID, S_AXI_BREADY, S_AXI_RREADY, req_en, run_on} = '0;
      {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, S_AXI_WSTRB, S_AXI_AWPROT, S_AXI_ARPROT, lim} = '0;
      RST = 1'b1;
      repeat (5) @(posedge REF_CLK);
      RST <= 1'b0;
      @(posedge REF_CLK);
      rd(12'h044, 32'h0000_0628, RESP_OKAY);
      rd(12'h048, 32'h0100_1203, RESP_OKAY);
      rd(12'h034, 32'h0000_2EDF, RESP_OKAY);
      wr(12'h044, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
      rd(12'h044, 32'h0000_3FFF, RESP_OKAY);
      wr(12'h048, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
      rd(12'h048, 32'hFF00_1B03, RESP_OKAY);
      wr(12'h0FC, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
      rd(12'h0FC, 32'h0000_0000, RESP_SLVERR);
      // limit leaves room for a short low-speed packet and is then left alone
      lim = 14'(5 + $urandom % 20);
      wr(12'h034, 32'(FLEN), 4'hF, RESP_OKAY);
      wr(12'h044, {18'h0, lim}, 4'hF, RESP_OKAY);
      wr(12'h004, 32'h0000_0001, 4'hF, RESP_OKAY);
      run_on <= 1'b1;
      req_en <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         s = 8'($urandom);
         // settle value written ahead of port use; only the top byte is strobed
         wr(12'h048, {s, 24'h00_0000}, 4'h8, RESP_OKAY);
         rd(12'h048, {s, 24'h00_1B03}, RESP_OKAY);
         frame_mark(t0);
         frame_mark(t1);
         chk({31'h0, (t1 - t0) / 8 inside {[LO:LO + 1]}}, 32'h0000_0001);
      end
      // wind down: deferral count, then stop the frame timer and read the frame count
      req_en <= 1'b0;
      repeat (3) @(posedge REF_CLK);
      rd(12'h054, 32'(n_defer), RESP_OKAY);
      wr(12'h054, 32'h0000_0000, 4'hF, RESP_OKAY);
      rd(12'h054, 32'h0000_0000, RESP_OKAY);
      wr(12'h004, 32'h0000_0000, 4'hF, RESP_OKAY);
      run_on <= 1'b0;
      wr(12'h038, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
      rd(12'h038, 32'h0000_0000, RESP_OKAY);
      rd(12'h004, 32'h0000_0000, RESP_OKAY);
      rd(12'h03C, 32'(n_frames), RESP_OKAY);
      give_verdict();
   end
endmodule : lowspeed_threshold_roothub_timing_tb_top
